// File: rtl/rsq_reset_sequencer.sv
`timescale 1ns/1ps
`include "rsq_cfg.svh"

// ----------------------------------------------------------------
// How it works
// ----------------------------------------------------------------
// How it works
// - external reset waits for bus cycle end or the bus monitor timeout
// - latched external reset keeps the pin driven low another 512 cycles
// - internal request drives pin low at least 512 cycles, longer while held
// - after driving, release pin ten cycles, then test; high starts reset processing
// - low at the test drives another 512 cycles and repeats the test
// - system pins go high-Z or inactive while reset is asserted
// - module port pins are high-Z following reset
// - power-on drives both lines until clock lock plus 512 cycles
// - modules reset after clock runs and master reset held four cycles
// - three-state input held about ten cycles forces all drivers high-Z
// - after three-state takes effect only a full restart recovers
// - reset is taken at end of a bus cycle, processing aborted
// - master reset line asserts after request synchronisation
// - master reset sets mask 7, stop-disable, clears saturation and bank extensions
// - condition code bits not named above are left untouched by reset
// - breakpoint input sampled when master reset negates
// - vectors fetched: bank extensions, program counter, stack pointer, index
// - vectors come from internal RAM or boot chip-select external ROM
// - fetch starts at program bank extension joined with program counter
// - cause register sets a bit for every cause present
// - cause register updates at the pin test that finds the pin high, as master reset negates
// - vectors lie in bottom 512 bytes of bank 0, offset from vector number
module rsq_reset_sequencer (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic clkEn,
	// avalon-mm slave
	input wire logic [3:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWritedata,
	output logic [31:0] avsReaddata,
	output logic avsWaitrequest,
	// open-drain reset pin and external pins
	input wire logic resetPinIn,
	output logic resetPinOut,
	output logic resetPinOe,
	input wire logic threeStateControl,
	input wire logic breakpointIn_n,
	// on-chip sources
	input wire logic pllLocked,
	input wire logic internalResetReq,
	input wire logic busCycleEnd,
	// reset lines and pin enables
	output logic masterResetLine,
	output logic externalResetLine,
	output logic moduleReset,
	output logic sysPinOe,
	output logic modulePortHiZ,
	// processor state
	output rsq_pkg::rsq_cpu_t cpuState,
	output logic bdmEnable,
	// reset vector fetch
	output logic vecRead,
	output logic [19:0] vecAddr,
	output logic bootChipSelect,
	input wire logic vecAck,
	input wire logic [15:0] vecData,
	output logic fetchStart,
	output logic [19:0] fetchAddr
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// bank 0 word-sized vectors: displacement is twice the vector number
	function automatic logic [19:0] vecDisp(input logic [7:0] num);
		vecDisp = {11'h000, num, 1'b0};
	endfunction

	function automatic logic isAddr(input logic [3:0] a, input logic [3:0] off);
		isAddr = (a == off);
	endfunction

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pinSync;
	logic [1:0] tscSync;
	logic [1:0] bkptSync;

	always_ff @(posedge mclk) begin
		if (rst) begin
			pinSync <= 2'h3;
			tscSync <= 2'h0;
			bkptSync <= 2'h3;
		end else if (clkEn) begin
			pinSync <= {pinSync[0], resetPinIn};
			tscSync <= {tscSync[0], threeStateControl};
			bkptSync <= {bkptSync[0], breakpointIn_n};
		end
	end

	wire pinHigh = pinSync[1];
	wire tscHigh = tscSync[1];

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rsq_pkg::rsq_state_t state;
	logic [`RSQ_CNT_W-1:0] cnt;
	logic porActive;
	logic swReq;
	logic portEnable;
	logic bootFromRam;
	logic [3:0] tscCnt;
	logic [2:0] mstrCnt;
	logic [1:0] vecIdx;
	logic [15:0] pcVec;
	rsq_pkg::rsq_cause_t pending;
	rsq_pkg::rsq_cause_t causeReg;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire busReq = avsRead | avsWrite;
	wire wrTake = avsWrite & ~avsWaitrequest;
	wire wrCtrl = wrTake & isAddr(avsAddress, `RSQ_OFF_CTRL);
	wire reqSeen = ~pinHigh | internalResetReq | swReq;
	wire holdDone = busCycleEnd | (cnt == `RSQ_BUSMON_CYC - 10'd1);
	wire driveMin = (cnt >= `RSQ_DRIVE_CYC - 10'd1);
	wire lockOk = ~porActive | pllLocked;
	// a software request is a one-shot: it buys one drive period, only the internal line or, at power-on, a missing clock lock can stretch it
	wire driveDone = driveMin & lockOk & ~internalResetReq;
	wire relDone = (cnt == `RSQ_RELEASE_CYC - 10'd1);
	wire tscTaken = (tscCnt == `RSQ_TSC_CYC - 4'd1) & tscHigh;
	wire dead = (state == rsq_pkg::ST_DEAD);
	wire inReset = (state == rsq_pkg::ST_DRIVE) | (state == rsq_pkg::ST_RELEASE);
	wire [`RSQ_CNT_W-1:0] cntInc = cnt + 10'd1;
	wire [31:0] statusWord = {16'h0000, 3'h0, porActive, dead, bdmEnable, moduleReset,
		masterResetLine, cpuState.interruptMaskField, cpuState.stopDisable,
		cpuState.saturationModeBit, state};
	wire [31:0] readMux = isAddr(avsAddress, `RSQ_OFF_CTRL) ?
			{29'h0, bootFromRam, portEnable, swReq} :
		isAddr(avsAddress, `RSQ_OFF_CAUSE) ? {28'h0, causeReg} :
		isAddr(avsAddress, `RSQ_OFF_STATUS) ? statusWord :
		isAddr(avsAddress, `RSQ_OFF_FETCH) ? {12'h000, fetchAddr} : 32'h0000_0000;
	rsq_pkg::rsq_cause_t newCause;
	assign newCause = '{sw: swReq, intr: internalResetReq, ext: ~pinHigh, por: 1'b0};

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	// one wait cycle on every access keeps read data a clean flop
	always_ff @(posedge mclk) begin
		if (rst) begin
			avsWaitrequest <= 1'b1;
			avsReaddata <= 32'h0000_0000;
		end else if (clkEn) begin
			avsWaitrequest <= ~(busReq & avsWaitrequest);
			if (avsRead & avsWaitrequest)
				avsReaddata <= readMux;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			portEnable <= 1'b0;
			bootFromRam <= 1'b0;
		end else if (clkEn) begin
			if (wrCtrl) begin
				portEnable <= avsWritedata[`RSQ_CTRL_PORTEN];
				bootFromRam <= avsWritedata[`RSQ_CTRL_BOOTRAM];
			end else if (moduleReset) begin
				portEnable <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// three-state control
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst)
			tscCnt <= 4'h0;
		else if (clkEn)
			tscCnt <= (tscHigh & ~tscTaken) ? tscCnt + 4'd1 : 4'h0;
	end

	// ----------------------------------------------------------------
	// reset sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= rsq_pkg::ST_DRIVE;
			cnt <= '0;
			porActive <= 1'b1;
			swReq <= 1'b0;
			pending <= '{sw: 1'b0, intr: 1'b0, ext: 1'b0, por: 1'b1};
			causeReg <= '0;
			masterResetLine <= 1'b1;
			externalResetLine <= 1'b1;
			resetPinOe <= 1'b1;
			vecIdx <= 2'h0;
			fetchStart <= 1'b0;
		end else if (clkEn) begin
			fetchStart <= 1'b0;
			if (wrCtrl & avsWritedata[`RSQ_CTRL_SWRST])
				swReq <= 1'b1;
			if (tscTaken) begin
				state <= rsq_pkg::ST_DEAD;
				resetPinOe <= 1'b0;
			end else begin
				case (state)
					rsq_pkg::ST_RUN: begin
						if (reqSeen) begin
							state <= rsq_pkg::ST_HOLD;
							cnt <= '0;
							pending <= pending | newCause;
						end
					end
					rsq_pkg::ST_HOLD: begin
						cnt <= cntInc;
						pending <= pending | newCause;
						if (holdDone) begin
							state <= rsq_pkg::ST_DRIVE;
							cnt <= '0;
							masterResetLine <= 1'b1;
							externalResetLine <= 1'b1;
							resetPinOe <= 1'b1;
						end
					end
					rsq_pkg::ST_DRIVE: begin
						pending <= pending | rsq_pkg::rsq_cause_t'{sw: swReq, intr: internalResetReq, ext: 1'b0, por: 1'b0};
						if (porActive & ~pllLocked)
							cnt <= '0;
						else if (!driveMin)
							cnt <= cntInc;
						if (driveDone) begin
							state <= rsq_pkg::ST_RELEASE;
							cnt <= '0;
							resetPinOe <= 1'b0;
							// a request written in this very cycle survives the clear
							swReq <= wrCtrl & avsWritedata[`RSQ_CTRL_SWRST];
						end
					end
					rsq_pkg::ST_RELEASE: begin
						cnt <= cntInc;
						if (relDone) begin
							cnt <= '0;
							if (pinHigh) begin
								state <= rsq_pkg::ST_VECTOR;
								causeReg <= pending;
								pending <= '0;
								porActive <= 1'b0;
								masterResetLine <= 1'b0;
								externalResetLine <= 1'b0;
								vecIdx <= 2'h0;
							end else begin
								state <= rsq_pkg::ST_DRIVE;
								resetPinOe <= 1'b1;
								pending.ext <= 1'b1;
							end
						end
					end
					rsq_pkg::ST_VECTOR: begin
						if (vecAck) begin
							vecIdx <= vecIdx + 2'd1;
							if (vecIdx == `RSQ_VEC_LAST) begin
								state <= rsq_pkg::ST_RUN;
								fetchStart <= 1'b1;
							end
						end
					end
					rsq_pkg::ST_DEAD: begin
						resetPinOe <= 1'b0;
					end
					default: begin
						state <= rsq_pkg::ST_DRIVE;
						resetPinOe <= 1'b1;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// processor state and vector loading
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			cpuState <= '{interruptMaskField: `RSQ_IMASK_RST, stopDisable: 1'b1,
				saturationModeBit: 1'b0, zBankExtension: 4'h0, stackBankExtension: 4'h0,
				programBankExtension: 4'h0};
			pcVec <= 16'h0000;
			fetchAddr <= 20'h00000;
			bdmEnable <= 1'b0;
		end else if (clkEn) begin
			if (masterResetLine) begin
				// other condition code bits are deliberately not touched here
				cpuState.interruptMaskField <= `RSQ_IMASK_RST;
				cpuState.stopDisable <= 1'b1;
				cpuState.saturationModeBit <= 1'b0;
				{cpuState.zBankExtension, cpuState.stackBankExtension,
					cpuState.programBankExtension} <= `RSQ_BANKEXT_RST;
			end
			if ((state == rsq_pkg::ST_RELEASE) & relDone & pinHigh)
				bdmEnable <= ~bkptSync[1];
			if ((state == rsq_pkg::ST_VECTOR) & vecAck) begin
				case (vecIdx)
					2'h0: {cpuState.zBankExtension, cpuState.stackBankExtension,
						cpuState.programBankExtension} <= vecData[11:0];
					2'h1: pcVec <= vecData;
					2'h3: fetchAddr <= {cpuState.programBankExtension, pcVec};
					default: pcVec <= pcVec;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// vector bus requests
	// ----------------------------------------------------------------
	// stack pointer and index words are handed to the core on vecData;
	// only the words this block needs are kept
	always_ff @(posedge mclk) begin
		if (rst) begin
			vecRead <= 1'b0;
			vecAddr <= 20'h00000;
			bootChipSelect <= 1'b0;
		end else if (clkEn) begin
			vecRead <= (state == rsq_pkg::ST_VECTOR) & ~vecAck & ~tscTaken;
			vecAddr <= vecDisp({6'h00, vecIdx} + {7'h00, vecAck});
			bootChipSelect <= (state == rsq_pkg::ST_VECTOR) & ~vecAck & ~bootFromRam & ~tscTaken;
		end
	end

	// ----------------------------------------------------------------
	// module reset and pin enables
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			mstrCnt <= 3'h0;
			moduleReset <= 1'b0;
			sysPinOe <= 1'b0;
			modulePortHiZ <= 1'b1;
			resetPinOut <= 1'b0;
		end else if (clkEn) begin
			resetPinOut <= 1'b0;
			if (!masterResetLine)
				mstrCnt <= 3'h0;
			else if (pllLocked & (mstrCnt != `RSQ_MASTER_MIN_CYC))
				mstrCnt <= mstrCnt + 3'd1;
			moduleReset <= masterResetLine & (mstrCnt == `RSQ_MASTER_MIN_CYC);
			sysPinOe <= ~masterResetLine & ~inReset & ~dead & ~tscTaken;
			modulePortHiZ <= moduleReset | dead | tscTaken | ~portEnable;
		end
	end

endmodule

// File: rtl/rsq_cfg.svh
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RSQ_OFF_CTRL 4'h0
`define RSQ_OFF_CAUSE 4'h4
`define RSQ_OFF_STATUS 4'h8
`define RSQ_OFF_FETCH 4'hc

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define RSQ_CTRL_SWRST 0
`define RSQ_CTRL_PORTEN 1
`define RSQ_CTRL_BOOTRAM 2

// ----------------------------------------------------------------
// timing counts, in mclk cycles
// ----------------------------------------------------------------
`define RSQ_CNT_W 10
`define RSQ_DRIVE_CYC 10'd512
`define RSQ_RELEASE_CYC 10'd10
`define RSQ_MASTER_MIN_CYC 3'd4
`define RSQ_TSC_CYC 4'd10
`define RSQ_BUSMON_CYC 10'd64

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RSQ_IMASK_RST 3'h7
`define RSQ_BANKEXT_RST 12'h000
`define RSQ_VEC_LAST 2'h3

`endif

// File: rtl/rsq_pkg.sv
package rsq_pkg;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_HOLD = 3'b001,
		ST_DRIVE = 3'b010,
		ST_RELEASE = 3'b011,
		ST_VECTOR = 3'b100,
		ST_DEAD = 3'b101
	} rsq_state_t;

	// one bit per reset source
	typedef struct packed {
		logic sw;
		logic intr;
		logic ext;
		logic por;
	} rsq_cause_t;

	// processor state set up by the master reset line
	typedef struct packed {
		logic [2:0] interruptMaskField;
		logic stopDisable;
		logic saturationModeBit;
		logic [3:0] zBankExtension;
		logic [3:0] stackBankExtension;
		logic [3:0] programBankExtension;
	} rsq_cpu_t;

endpackage

// File: sim/rsq_reset_sequencer_assertions.sv
`timescale 1ns/1ps
module rsq_reset_sequencer_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pins and lines
	input wire logic threeStateControl,
	input wire logic pllLocked,
	input wire logic resetPinOut,
	input wire logic resetPinOe,
	input wire logic masterResetLine,
	input wire logic moduleReset,
	input wire logic sysPinOe,
	input wire logic modulePortHiZ,
	input wire rsq_pkg::rsq_cpu_t cpuState,
	// vector fetch
	input wire logic vecRead,
	input wire logic [19:0] vecAddr,
	input wire logic vecAck,
	input wire logic fetchStart
);
	logic [10:0] oeCnt;
	logic [3:0] relCnt;
	logic [3:0] tscCnt;
	logic [2:0] mCnt;
	logic [19:0] nextVec;
	// ----
	// helper counters
	// ----
	always_ff @(posedge mclk) begin
		if (rst) begin
			oeCnt <= 11'h0;
			relCnt <= 4'h0;
			tscCnt <= 4'h0;
		end else begin
			oeCnt <= resetPinOe ? oeCnt + 11'h1 : 11'h0;
			relCnt <= (!resetPinOe && masterResetLine) ? relCnt + 4'h1 : 4'h0;
			tscCnt <= !threeStateControl ? 4'h0 : (tscCnt == 4'hf ? tscCnt : tscCnt + 4'h1);
		end
		mCnt <= !(masterResetLine && pllLocked) ? 3'h0 : (mCnt == 3'h7 ? mCnt : mCnt + 3'h1);
		nextVec <= masterResetLine ? 20'h0 : ((vecRead && vecAck) ? vecAddr + 20'h2 : nextVec);
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	chk_pin_open_drain: assert property (resetPinOut == 1'b0) else $error("reset pin driven high");
	chk_drive_long: assert property ($fell(resetPinOe) && tscCnt == 4'h0 |-> oeCnt >= 11'h200)
		else $error("drive period shorter than 512");
	chk_release_ten: assert property (($fell(masterResetLine) || ($rose(resetPinOe) && $past(masterResetLine)))
		&& tscCnt == 4'h0 |-> relCnt == 4'ha) else $error("release window not ten cycles");
	chk_mask_seven: assert property (masterResetLine && $past(masterResetLine) |-> cpuState.interruptMaskField == 3'h7
		&& cpuState.stopDisable && !cpuState.saturationModeBit && cpuState[11:0] == 12'h000)
		else $error("processor state not initialised");
	chk_pins_quiet: assert property (masterResetLine && $past(masterResetLine) |-> !sysPinOe)
		else $error("system pins enabled in reset");
	chk_module_late: assert property ($rose(moduleReset) |-> mCnt >= 3'h4) else $error("module reset early");
	chk_ports_hiz: assert property (moduleReset && $past(moduleReset) |-> modulePortHiZ)
		else $error("module ports driven in reset");
	chk_vec_hold: assert property (vecRead && !vecAck |=> vecRead && $stable(vecAddr))
		else $error("vector request dropped");
	chk_vec_order: assert property (vecRead |-> vecAddr == nextVec) else $error("vector address out of order");
	chk_fetch_pulse: assert property (fetchStart |-> !masterResetLine ##1 !fetchStart)
		else $error("fetch start not a single pulse");
	chk_tsc_dead: assert property (tscCnt == 4'hf |-> !resetPinOe && !sysPinOe && !vecRead)
		else $error("drivers active under three-state");
endmodule

bind rsq_reset_sequencer rsq_reset_sequencer_checker rsq_reset_sequencer_checker_i (.*);

// File: sim/rsq_far_side.sv
`timescale 1ns/1ps
module rsq_far_side (
	// bench controls
	input wire logic mclk,
	input wire logic extPull,
	input wire logic [3:0] ackDelay,
	// reset pin
	input wire logic resetPinOe,
	output logic resetPinIn,
	// vector memory
	input wire logic vecRead,
	input wire logic [19:0] vecAddr,
	output logic vecAck,
	output logic [15:0] vecData
);
	logic [3:0] waitCnt = 4'h0;
	logic [15:0] word;
	initial vecAck = 1'b0;
	// pull-up: the pin reads high unless a party sinks it
	assign resetPinIn = !(resetPinOe || extPull);
	assign word = vecAddr[2:1] == 2'h0 ? 16'h0123 : vecAddr[2:1] == 2'h1 ? 16'h4560 :
		vecAddr[2:1] == 2'h2 ? 16'h7ffe : 16'h0800;
	// bus shows junk outside an acknowledge, never the last word
	assign vecData = vecAck ? word : ~word;
	always @(posedge mclk) begin
		vecAck <= vecRead && !vecAck && waitCnt >= ackDelay;
		waitCnt <= (vecRead && !vecAck) ? waitCnt + 4'h1 : 4'h0;
	end
endmodule

// File: sim/rsq_reset_sequencer_tb.sv
`timescale 1ns/1ps
module rsq_reset_sequencer_tb;
	logic mclk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0, pllLocked = 1'b0;
	logic internalResetReq = 1'b0, busCycleEnd = 1'b1, threeStateControl = 1'b0;
	logic breakpointIn_n = 1'b0, extPull = 1'b0;
	logic [3:0] avsAddress = 4'h0, ackDelay = 4'h3;
	logic [31:0] avsWritedata = 32'h0, avsReaddata, rd;
	logic avsWaitrequest, resetPinIn, resetPinOut, resetPinOe, masterResetLine, externalResetLine;
	logic moduleReset, sysPinOe, modulePortHiZ, bdmEnable, vecRead, bootChipSelect, vecAck, fetchStart;
	logic [19:0] vecAddr, fetchAddr;
	logic [15:0] vecData;
	rsq_pkg::rsq_cpu_t cpuState;
	int bad_count = 0, tests_run = 0;
	rsq_reset_sequencer rsq_reset_sequencer_i (.mclk(mclk), .rst(rst), .clkEn(1'b1),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
		.avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .resetPinIn(resetPinIn),
		.resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .threeStateControl(threeStateControl),
		.breakpointIn_n(breakpointIn_n), .pllLocked(pllLocked), .internalResetReq(internalResetReq),
		.busCycleEnd(busCycleEnd), .masterResetLine(masterResetLine), .externalResetLine(externalResetLine),
		.moduleReset(moduleReset), .sysPinOe(sysPinOe), .modulePortHiZ(modulePortHiZ), .cpuState(cpuState),
		.bdmEnable(bdmEnable), .vecRead(vecRead), .vecAddr(vecAddr), .bootChipSelect(bootChipSelect),
		.vecAck(vecAck), .vecData(vecData), .fetchStart(fetchStart), .fetchAddr(fetchAddr));
	rsq_far_side rsq_far_side_i (.mclk(mclk), .extPull(extPull), .ackDelay(ackDelay), .resetPinOe(resetPinOe),
		.resetPinIn(resetPinIn), .vecRead(vecRead), .vecAddr(vecAddr), .vecAck(vecAck), .vecData(vecData));
	// ----
	// tasks
	// ----
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, s);
			bad_count++;
		end
	endtask
	// entered just after a rising edge; holds the request until waitrequest low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avsAddress <= a;
		avsWritedata <= d;
		avsWrite <= w;
		avsRead <= !w;
		@(posedge mclk);
		while (avsWaitrequest !== 1'b0) @(posedge mclk);
		rd = avsReaddata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge mclk);
	endtask
	// 0 master low, 1 master high, 2 vector read, 3 fetch start
	task waitc(input int s, input int n);
		int i;
		i = 0;
		while (i < n && !(s == 0 ? masterResetLine === 1'b0 : s == 1 ? masterResetLine === 1'b1 :
			s == 2 ? vecRead === 1'b1 : fetchStart === 1'b1)) begin
			@(posedge mclk);
			i++;
		end
	endtask
	initial begin
		forever #25 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		stop_test;
	end
	// ----
	// scenarios
	// ----
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (40) @(posedge mclk);
		pllLocked <= 1'b1;
		repeat (500) @(posedge mclk);
		chk("pin", resetPinOe, 32'h1);
		chk("extline", externalResetLine, 32'h1);
		waitc(2, 200);
		chk("bootcs", bootChipSelect, 32'h1);
		waitc(3, 200);
		chk("fetchaddr", fetchAddr, 32'h34560);
		chk("banks", cpuState[11:0], 32'h123);
		chk("bdm", bdmEnable, 32'h1);
		bus(1'b0, 4'h4, 32'h0);
		chk("cause por", rd, 32'h1);
		bus(1'b1, 4'h4, 32'hf);
		bus(1'b0, 4'h4, 32'h0);
		chk("cause ro", rd, 32'h1);
		bus(1'b0, 4'h3, 32'h0);
		chk("unmapped", rd, 32'h0);
		bus(1'b0, 4'hc, 32'h0);
		chk("fetchreg", rd, 32'h34560);
		bus(1'b1, 4'h0, 32'h2);
		@(posedge mclk);
		chk("port on", modulePortHiZ, 32'h0);
		// external reset arriving mid bus cycle, held over two pin tests
		breakpointIn_n <= 1'b1;
		busCycleEnd <= 1'b0;
		extPull <= 1'b1;
		ackDelay <= 4'h0;
		repeat (20) @(posedge mclk);
		chk("held off", masterResetLine, 32'h0);
		busCycleEnd <= 1'b1;
		waitc(1, 10);
		chk("master on", masterResetLine, 32'h1);
		repeat (1100) @(posedge mclk);
		bus(1'b0, 4'h4, 32'h0);
		chk("cause held", rd, 32'h1);
		extPull <= 1'b0;
		waitc(0, 1200);
		chk("ext done", masterResetLine, 32'h0);
		chk("port hiz", modulePortHiZ, 32'h1);
		chk("no bdm", bdmEnable, 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		chk("cause ext", rd, 32'h2);
		// software and internal requests together
		bus(1'b1, 4'h0, 32'h1);
		internalResetReq <= 1'b1;
		repeat (700) @(posedge mclk);
		chk("intr drive", resetPinOe, 32'h1);
		internalResetReq <= 1'b0;
		waitc(0, 700);
		chk("intr done", masterResetLine, 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		chk("cause both", rd, 32'hc);
		// three-state held, then a late request must stay unanswered
		chk("sys on", sysPinOe, 32'h1);
		threeStateControl <= 1'b1;
		repeat (16) @(posedge mclk);
		chk("tsc pin", resetPinOe, 32'h0);
		chk("tsc sys", sysPinOe, 32'h0);
		internalResetReq <= 1'b1;
		repeat (20) @(posedge mclk);
		chk("dead", resetPinOe, 32'h0);
		bus(1'b0, 4'h8, 32'h0);
		chk("dead flag", rd[11], 32'h1);
		chk("dead master", rd[8], 32'h0);
		stop_test;
	end
endmodule
